// *** verilog/ocr_bank.v ***
// ocr_bank.v: control settings bank of an on-screen display generator
// assumes: avalon-mm master on sys_clk_i, single clock, async active-high reset
//
// Function
// - reset clears both scan mode bits, selecting single-rate 525/625 line operation.
// - reset sets output polarity bit, outputs active high.
// - reset clears display enable; display stays off until software enables.
// - reset clears hsync polarity bit, hsync input active low.
// - reset clears vsync polarity bit, vsync input active low.
// - reset loads shadow mode upper 0, lower 1: north-west shadowing.
// - reset clears blink rate bits: vsync frequency divided by sixteen.
// - reset clears blink duty bits: on-to-off ratio three to one.
// - reset clears port function bit: shared pin is general output port.
// - reset sets frame colour to blue only.
// - reset clears command bank bits: bank zero active.
// - auxiliary output low after reset until a space code changes it.
// - background blue after reset until a space code changes it.
// - character size cleared after reset; only carriage-return code changes it.
// - end-of-display flag cleared after reset; display continues.
`timescale 1ns/1ps
`include "ocr_defs.vh"

module ocr_bank (
   input  wire        sys_clk_i,
   input  wire        rst_i,
   input  wire        clk_en_i,
   input  wire [5:0]  avs_address_i,
   input  wire        avs_read_i,
   input  wire        avs_write_i,
   input  wire [31:0] avs_writedata_i,
   input  wire [3:0]  avs_byteenable_i,
   output reg  [31:0] avs_readdata_o,
   output wire        avs_waitrequest_o,
   output wire [1:0]  scan_mode_o,
   output wire        output_polarity_bit_o,
   output wire        display_enable_o,
   output wire        hsync_polarity_bit_o,
   output wire        vsync_polarity_bit_o,
   output wire [1:0]  shadow_mode_o,
   output wire [1:0]  blink_rate_o,
   output wire [1:0]  blink_duty_o,
   output wire        port_function_o,
   output wire [3:0]  frame_colour_o,
   output wire [1:0]  command_bank_o,
   output wire        auxiliary_output_o,
   output wire [3:0]  background_colour_o,
   output wire [1:0]  char_size_o,
   output wire        end_of_display_flag_o
);

   // ==========================================================
   // bus handshake
   // one wait cycle on every access so read data come from a flop;
   // a low clock enable holds the answer back rather than dropping it
   localparam [1:0]      ST_IDLE = 2'h1;
   localparam [1:0]      ST_ANS  = 2'h2;

   reg  [1:0]            st_q;
   reg  [1:0]            st_d;
   reg                   ack_q;
   wire                  req   = (avs_read_i | avs_write_i) & clk_en_i;
   wire                  ans   = ack_q & clk_en_i;
   wire                  wr_go = avs_write_i & ans & avs_byteenable_i[0];
   wire                  rd_ld = avs_read_i & ~ack_q & clk_en_i;

   assign avs_waitrequest_o = ~ans;

   always @* begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (req) begin
               st_d = ST_ANS;
            end
         end
         ST_ANS: begin
            st_d = ST_IDLE;
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q  <= ST_IDLE;
         ack_q <= 1'b0;
      end else if (clk_en_i) begin
         st_q  <= st_d;
         ack_q <= st_d[1];
      end
   end

   // ==========================================================
   // write strobes; writes without byte lane 0 are dropped
   wire                  we_c1   = wr_go & (avs_address_i == `OCR_OFF_CTRL1);
   wire                  we_c2   = wr_go & (avs_address_i == `OCR_OFF_CTRL2);
   wire                  we_c3   = wr_go & (avs_address_i == `OCR_OFF_CTRL3);
   wire                  we_c4   = wr_go & (avs_address_i == `OCR_OFF_CTRL4);
   wire                  we_c5   = wr_go & (avs_address_i == `OCR_OFF_CTRL5);
   wire                  we_code = wr_go & (avs_address_i == `OCR_OFF_CODE);

   // ==========================================================
   // directly controlled settings, one flop group per field
   // separate flops keep each reset value beside its field,
   // at the price of a wider readback concatenation

   // scan mode select, both bits
   reg  [1:0]            scan_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         scan_q <= `OCR_SCAN_RST;
      end else if (we_c1) begin
         scan_q <= {avs_writedata_i[`OCR_C1_SCAN_HI], avs_writedata_i[`OCR_C1_SCAN_LO]};
      end
   end

   // output polarity
   reg                   outpol_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         outpol_q <= `OCR_OUTPOL_RST;
      end else if (we_c1) begin
         outpol_q <= avs_writedata_i[`OCR_C1_OUTPOL];
      end
   end

   // display enable
   reg                   en_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         en_q <= `OCR_EN_RST;
      end else if (we_c1) begin
         en_q <= avs_writedata_i[`OCR_C1_EN];
      end
   end

   // hsync input polarity
   reg                   hpol_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hpol_q <= `OCR_HPOL_RST;
      end else if (we_c2) begin
         hpol_q <= avs_writedata_i[`OCR_C2_HPOL];
      end
   end

   // vsync input polarity
   reg                   vpol_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         vpol_q <= `OCR_VPOL_RST;
      end else if (we_c2) begin
         vpol_q <= avs_writedata_i[`OCR_C2_VPOL];
      end
   end

   // shadow mode select
   reg  [1:0]            shadow_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shadow_q <= `OCR_SHADOW_RST;
      end else if (we_c2) begin
         shadow_q <= {avs_writedata_i[`OCR_C2_SH_HI], avs_writedata_i[`OCR_C2_SH_LO]};
      end
   end

   // blink rate
   reg  [1:0]            rate_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rate_q <= `OCR_RATE_RST;
      end else if (we_c3) begin
         rate_q <= avs_writedata_i[`OCR_C3_RATE+1:`OCR_C3_RATE];
      end
   end

   // blink duty
   reg  [1:0]            duty_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         duty_q <= `OCR_DUTY_RST;
      end else if (we_c3) begin
         duty_q <= avs_writedata_i[`OCR_C3_DUTY+1:`OCR_C3_DUTY];
      end
   end

   // port function of the shared pin
   reg                   port_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         port_q <= `OCR_PORT_RST;
      end else if (we_c4) begin
         port_q <= avs_writedata_i[`OCR_C4_PORT];
      end
   end

   // frame background colour i,b,g,r
   reg  [3:0]            frame_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_q <= `OCR_FRAME_RST;
      end else if (we_c5) begin
         frame_q <= avs_writedata_i[`OCR_C5_FRAME+3:`OCR_C5_FRAME];
      end
   end

   // command bank select
   reg  [1:0]            bank_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bank_q <= `OCR_BANK_RST;
      end else if (we_c5) begin
         bank_q <= avs_writedata_i[`OCR_C5_BANK+1:`OCR_C5_BANK];
      end
   end

   // ==========================================================
   // indirectly controlled settings, changed only by display codes
   // code word: [1:0] kind, [2] aux, [6:3] colour i,b,g,r, [8:7] size
   wire [1:0]            code_kind = avs_writedata_i[1:0];
   wire                  code_sp   = we_code & (code_kind == `OCR_CODE_SPACE);
   wire                  code_cr   = we_code & (code_kind == `OCR_CODE_CR);

   // auxiliary output level
   reg                   aux_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aux_q <= `OCR_AUX_RST;
      end else if (code_sp) begin
         aux_q <= avs_writedata_i[`OCR_CODE_AUX];
      end
   end

   // background colour i,b,g,r
   reg  [3:0]            bg_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bg_q <= `OCR_BG_RST;
      end else if (code_sp) begin
         bg_q <= avs_writedata_i[`OCR_CODE_COL+3:`OCR_CODE_COL];
      end
   end

   // character size
   reg  [1:0]            size_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         size_q <= `OCR_SIZE_RST;
      end else if (code_cr) begin
         size_q <= avs_writedata_i[`OCR_CODE_SIZE+1:`OCR_CODE_SIZE];
      end
   end

   // end of display; any code but the end code lets the display run on
   reg                   eod_q;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         eod_q <= `OCR_EOD_RST;
      end else if (we_code) begin
         eod_q <= (code_kind == `OCR_CODE_END);
      end
   end

   // ==========================================================
   // read path; unmapped and write-only offsets read as zero
   // loaded while waitrequest is still high, so data stand at the answer
   wire [31:0]           rd_c1  = {28'h0000000, en_q, outpol_q, scan_q};
   wire [31:0]           rd_c2  = {28'h0000000, shadow_q, vpol_q, hpol_q};
   wire [31:0]           rd_c3  = {28'h0000000, duty_q, rate_q};
   wire [31:0]           rd_c4  = {31'h00000000, port_q};
   wire [31:0]           rd_c5  = {26'h0000000, bank_q, frame_q};
   wire [31:0]           rd_ind = {24'h000000, bg_q, aux_q, size_q, eod_q};

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         avs_readdata_o <= 32'h00000000;
      end else if (rd_ld) begin
         case (avs_address_i)
            `OCR_OFF_CTRL1: begin
               avs_readdata_o <= rd_c1;
            end
            `OCR_OFF_CTRL2: begin
               avs_readdata_o <= rd_c2;
            end
            `OCR_OFF_CTRL3: begin
               avs_readdata_o <= rd_c3;
            end
            `OCR_OFF_CTRL4: begin
               avs_readdata_o <= rd_c4;
            end
            `OCR_OFF_CTRL5: begin
               avs_readdata_o <= rd_c5;
            end
            `OCR_OFF_IND: begin
               avs_readdata_o <= rd_ind;
            end
            default: begin
               avs_readdata_o <= 32'h00000000;
            end
         endcase
      end
   end

   // ==========================================================
   // setting outputs
   // host must program settings not covered above itself
   assign scan_mode_o           = scan_q;
   assign output_polarity_bit_o = outpol_q;
   assign display_enable_o      = en_q;
   assign hsync_polarity_bit_o  = hpol_q;
   assign vsync_polarity_bit_o  = vpol_q;
   assign shadow_mode_o         = shadow_q;
   assign blink_rate_o          = rate_q;
   assign blink_duty_o          = duty_q;
   assign port_function_o       = port_q;
   assign frame_colour_o        = frame_q;
   assign command_bank_o        = bank_q;
   assign auxiliary_output_o    = aux_q;
   assign background_colour_o   = bg_q;
   assign char_size_o           = size_q;
   assign end_of_display_flag_o = eod_q;

endmodule

// *** verilog/ocr_defs.vh ***
// ocr_defs.vh: offsets, field positions and reset values of the osd control bank
// assumes: included by the bank module; 32-bit avalon word addressing in bytes
`ifndef OCR_DEFS_VH
`define OCR_DEFS_VH

// ==========================================================
// register byte offsets
`define OCR_OFF_CTRL1      6'h00
`define OCR_OFF_CTRL2      6'h04
`define OCR_OFF_CTRL3      6'h08
`define OCR_OFF_CTRL4      6'h0C
`define OCR_OFF_CTRL5      6'h10
`define OCR_OFF_IND        6'h14
`define OCR_OFF_CODE       6'h18

// ==========================================================
// ctrl1: scan mode, output polarity, enable
`define OCR_C1_SCAN_LO     0
`define OCR_C1_SCAN_HI     1
`define OCR_C1_OUTPOL      2
`define OCR_C1_EN          3
`define OCR_C1_W           4
`define OCR_C1_RST         4'h4
// ctrl2: sync polarities, shadow mode
`define OCR_C2_HPOL        0
`define OCR_C2_VPOL        1
`define OCR_C2_SH_LO       2
`define OCR_C2_SH_HI       3
`define OCR_C2_W           4
`define OCR_C2_RST         4'h4
// ctrl3: blink rate [1:0], blink duty [3:2]
`define OCR_C3_W           4
`define OCR_C3_RST         4'h0
// ctrl4: port function
`define OCR_C4_W           1
`define OCR_C4_RST         1'h0
// ctrl5: frame colour i,b,g,r [3:0], command bank [5:4]
`define OCR_C5_W           6
`define OCR_C5_RST         6'h04
// indirect: end [0], size lo [1], size hi [2], aux [3], colour i,b,g,r [7:4]
`define OCR_IND_W          8
`define OCR_IND_RST        8'h40
// display code kinds written to the code register
`define OCR_CODE_SPACE     2'h1
`define OCR_CODE_CR        2'h2
`define OCR_CODE_END       2'h3

// ==========================================================
// field positions of the split registers and of the code word
`define OCR_C3_RATE        0
`define OCR_C3_DUTY        2
`define OCR_C4_PORT        0
`define OCR_C5_FRAME       0
`define OCR_C5_BANK        4
`define OCR_CODE_AUX       2
`define OCR_CODE_COL       3
`define OCR_CODE_SIZE      7

// ==========================================================
// reset value of every field
`define OCR_SCAN_RST       2'h0
`define OCR_OUTPOL_RST     1'h1
`define OCR_EN_RST         1'h0
`define OCR_HPOL_RST       1'h0
`define OCR_VPOL_RST       1'h0
`define OCR_SHADOW_RST     2'h1
`define OCR_RATE_RST       2'h0
`define OCR_DUTY_RST       2'h0
`define OCR_PORT_RST       1'h0
`define OCR_FRAME_RST      4'h4
`define OCR_BANK_RST       2'h0
`define OCR_AUX_RST        1'h0
`define OCR_BG_RST         4'h4
`define OCR_SIZE_RST       2'h0
`define OCR_EOD_RST        1'h0

`endif

// *** sim/ocr_bank_assertions.sv ***
// checker: bus answer timing, display code effects
// assumes: bound into ocr_bank, one clock
`timescale 1ns/1ps
module ocr_bank_chk (
   input wire        sys_clk_i, rst_i, clk_en_i, avs_read_i, avs_write_i,
   input wire        avs_waitrequest_o, auxiliary_output_o, end_of_display_flag_o,
   input wire [5:0]  avs_address_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0]  avs_byteenable_i, background_colour_o,
   input wire [1:0]  char_size_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // ==========
   // code word accepted at this edge, split by kind
   wire cw  = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == 6'h18;
   wire sp  = cw && avs_writedata_i[1:0] == 2'h1;
   wire crw = cw && avs_writedata_i[1:0] == 2'h2;
   wire ew  = cw && avs_writedata_i[1:0] == 2'h3;
   sequence req_s; (avs_read_i || avs_write_i) && avs_waitrequest_o && clk_en_i; endsequence
   sequence ans_s; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
   AST_WAIT: assert property (req_s |=> ans_s) else $error("answer timing");
   AST_AUX0: assert property ($fell(rst_i) |-> !auxiliary_output_o) else $error("aux");
   AST_BG0: assert property ($fell(rst_i) |-> background_colour_o == 4'h4)
      else $error("bg");
   AST_DSP0: assert property ($fell(rst_i) |-> !char_size_o && !end_of_display_flag_o)
      else $error("size or end");
   AST_AUX: assert property ($changed(auxiliary_output_o) |-> $past(sp)) else $error("aux");
   AST_BG: assert property ($changed(background_colour_o) |-> $past(sp)) else $error("bg");
   AST_SZ: assert property ($changed(char_size_o) |-> $past(crw)) else $error("size");
   AST_EOD: assert property (ew |=> end_of_display_flag_o) else $error("end");
endmodule
bind ocr_bank ocr_bank_chk chk_i (.*);

// *** sim/ocr_host.sv ***
// bus master model: one avalon access at a time
// assumes: slave drops waitrequest to answer
`timescale 1ns/1ps
module ocr_host (
   input  wire        sys_clk_i, avs_waitrequest_o,
   input  wire [31:0] avs_readdata_o,
   output reg  [5:0]  avs_address_i = 6'h00,
   output reg         avs_read_i = 1'b0, avs_write_i = 1'b0,
   output reg  [31:0] avs_writedata_i = 32'h0,
   output reg  [3:0]  avs_byteenable_i = 4'h0
);
   // read right after the edge, before its updates land: the sampled values
   task automatic xfer(input [5:0] a, input w, input [31:0] d, input [3:0] be,
                       output [31:0] q);
      begin
         @(posedge sys_clk_i);
         {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i, avs_byteenable_i}
            <= {a, !w, w, d, be};
         @(posedge sys_clk_i);
         while (avs_waitrequest_o) @(posedge sys_clk_i);
         q = avs_readdata_o;
         {avs_read_i, avs_write_i} <= 2'h0;
      end
   endtask
endmodule

// *** sim/ocr_bank_tb_top.sv ***
// bench: reset defaults, readback, display codes, refusals
// assumes: ocr_host drives the bus
`timescale 1ns/1ps
module ocr_bank_tb_top;
   reg         sys_clk_i = 1'b0, rst_i = 1'b1;
   wire [5:0]  avs_address_i;
   wire [31:0] avs_writedata_i, avs_readdata_o;
   wire [3:0]  avs_byteenable_i;
   wire        avs_read_i, avs_write_i, avs_waitrequest_o;
   wire [26:0] pv;
   integer     n_errors = 0, check_count = 0, j;
   reg  [31:0] s = 32'h30, g;
   reg  [26:0] ep;
   reg  [5:0]  a;
   reg         clk_en_i = 1'b1;
   ocr_host host (.*);
   ocr_bank dut (.*, .scan_mode_o(pv[26:25]), .output_polarity_bit_o(pv[24]),
      .display_enable_o(pv[23]), .hsync_polarity_bit_o(pv[22]), .vsync_polarity_bit_o(pv[21]),
      .shadow_mode_o(pv[20:19]), .blink_rate_o(pv[18:17]), .blink_duty_o(pv[16:15]),
      .port_function_o(pv[14]), .frame_colour_o(pv[13:10]), .command_bank_o(pv[9:8]),
      .background_colour_o(pv[7:4]), .auxiliary_output_o(pv[3]), .char_size_o(pv[2:1]),
      .end_of_display_flag_o(pv[0]));
   always #20 sys_clk_i = ~sys_clk_i;
   function [31:0] xs(input [31:0] v);
      begin
         v = v ^ (v << 13);
         v = v ^ (v >> 17);
         xs = v ^ (v << 5);
      end
   endfunction
   // end flag set by the end code only, every other code clears it
   function [7:0] nxt(input [7:0] i, input [31:0] c);
      case (c[1:0])
         2'h1: nxt = {c[6:3], c[2], i[2:1], 1'h0};
         2'h2: nxt = {i[7:3], c[8:7], 1'h0};
         2'h3: nxt = {i[7:1], 1'h1};
         default: nxt = {i[7:1], 1'h0};
      endcase
   endfunction
   // expected direct settings after a full-lane write
   function [26:0] dset(input [26:0] p, input [5:0] ad, input [31:0] d);
      begin
         dset = p;
         case (ad)
            6'h00: dset[26:23] = {d[1], d[0], d[2], d[3]};
            6'h04: dset[22:19] = {d[0], d[1], d[3], d[2]};
            6'h08: dset[18:15] = {d[1:0], d[3:2]};
            6'h0C: dset[14] = d[0];
            6'h10: dset[13:8] = {d[3:0], d[5:4]};
            default: dset = p;
         endcase
      end
   endfunction
   task chk(input [31:0] x, input [31:0] e);
      begin
         check_count = check_count + 1;
         if (x !== e) begin
            n_errors = n_errors + 1;
            $display("FAIL %0t got %h exp %h", $time, x, e);
         end
      end
   endtask
   task rst;
      begin
         rst_i <= 1'b1;
         repeat (20) @(posedge sys_clk_i);
         chk({5'h00, pv}, 32'h01081040);
         rst_i <= 1'b0;
         ep = 27'h1081040;
         @(posedge sys_clk_i);
         chk({5'h00, pv}, 32'h01081040);
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", check_count, n_errors);
         if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
         else $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      rst;
      for (j = 0; j < 32; j = j + 1) begin
         s = xs(s);
         a = 6'(j % 5 * 4);
         host.xfer(a, 1'b1, s, 4'hF, g);
         ep = dset(ep, a, s);
         host.xfer(a, 1'b0, 32'h0, 4'hF, g);
         chk(g, s & (a == 6'h0C ? 32'h1 : a == 6'h10 ? 32'h3F : 32'hF));
         s = xs(s);
         host.xfer(6'h18, 1'b1, s, 4'hF, g);
         ep[7:0] = nxt(ep[7:0], s);
         host.xfer(6'h14, 1'b0, 32'h0, 4'hF, g);
         chk(g, {24'h0, ep[7:0]});
         chk({5'h00, pv}, {5'h00, ep});
      end
      // corner: end code, then a space code must restart the display
      host.xfer(6'h18, 1'b1, 32'h3, 4'hF, g);
      host.xfer(6'h18, 1'b1, 32'h1FD, 4'hF, g);
      ep[7:0] = nxt(nxt(ep[7:0], 32'h3), 32'h1FD);
      host.xfer(6'h14, 1'b0, 32'h0, 4'hF, g);
      chk(g, {24'h0, ep[7:0]});
      host.xfer(6'h00, 1'b1, 32'h5, 4'hF, g);
      ep = dset(ep, 6'h00, 32'h5);
      host.xfer(6'h00, 1'b1, 32'hA, 4'h0, g);
      host.xfer(6'h00, 1'b0, 32'h0, 4'hF, g);
      chk(g, 32'h5);
      host.xfer(6'h3C, 1'b1, 32'hFF, 4'hF, g);
      host.xfer(6'h3C, 1'b0, 32'h0, 4'hF, g);
      chk(g, 32'h0);
      chk({5'h00, pv}, {5'h00, ep});
      // clock enable low: the access stalls and nothing moves
      @(posedge sys_clk_i);
      clk_en_i <= 1'b0;
      fork
         host.xfer(6'h00, 1'b1, 32'hA, 4'hF, g);
         begin
            repeat (8) @(posedge sys_clk_i);
            chk({31'h0, avs_waitrequest_o}, 32'h1);
            chk({5'h00, pv}, {5'h00, ep});
            clk_en_i <= 1'b1;
         end
      join
      ep = dset(ep, 6'h00, 32'hA);
      host.xfer(6'h00, 1'b0, 32'h0, 4'hF, g);
      chk(g, 32'hA);
      chk({5'h00, pv}, {5'h00, ep});
      rst;
      report_and_stop;
   end
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      n_errors = n_errors + 1;
      report_and_stop;
   end
endmodule
